// ===== fpe_flash_pe_ctrl.sv
// Flash program/erase control: setup, error and block-select registers
`timescale 1ns/1ps
module fpe_flash_pe_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fpe_pkg::fpe_mode_t mode,
    input wire logic flash_error,
    output fpe_pkg::fpe_flash_ctl_t flash_ctl,
    output logic irq
);
    logic wr;
    logic [11:0] addr;
    logic hit;
    logic [31:0] rdata;
    logic [7:0] ctrl1_r, ctrl1_nxt;
    logic [7:0] setup_r, setup_nxt;
    logic [7:0] ebh_r, ebh_nxt;
    logic [7:0] ebl_r, ebl_nxt;
    logic [fpe_pkg::FPE_NIRQ-1:0] mask_r, mask_nxt;
    logic [fpe_pkg::FPE_NIRQ-1:0] irq_stat;
    logic [fpe_pkg::FPE_NIRQ-1:0] irq_clr;
    logic [fpe_pkg::FPE_NIRQ-1:0] irq_evt;
    fpe_pkg::fpe_state_t state_r, state_nxt;
    logic err;
    logic clr_all;
    logic software_write_enable;
    logic [7:0] wb;

    function automatic logic is_wr(input logic [11:0] a, input logic [11:0] off, input logic w);
        is_wr = w && (a == off);
    endfunction

    assign wb = pwdata[7:0];
    assign err = setup_r[fpe_pkg::FPE_BIT_ERR];
    assign software_write_enable = ctrl1_r[fpe_pkg::FPE_BIT_SWE];
    assign clr_all = mode.hw_standby;

    fpe_apb u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .rdata_in(rdata),
        .map_hit(hit),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .wr_strobe(wr),
        .reg_addr(addr)
    );

    always_comb begin
        hit = (addr == fpe_pkg::FPE_OFF_CTRL1) || (addr == fpe_pkg::FPE_OFF_SETUP)
            || (addr == fpe_pkg::FPE_OFF_EBH) || (addr == fpe_pkg::FPE_OFF_EBL)
            || (addr == fpe_pkg::FPE_OFF_IRQ_STAT) || (addr == fpe_pkg::FPE_OFF_IRQ_MASK);
    end

    // First control register: verify bits plain, program and erase bits gated
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        if (clr_all) begin
            ctrl1_nxt = fpe_pkg::FPE_RST8;
        end else if (is_wr(addr, fpe_pkg::FPE_OFF_CTRL1, wr) && !mode.flash_disabled) begin
            ctrl1_nxt = wb & fpe_pkg::FPE_CTRL1_MASK;
            // Program entry needs enable and setup already set, and no error
            if (!(software_write_enable && setup_r[fpe_pkg::FPE_BIT_PSU] && !err)) begin
                ctrl1_nxt[fpe_pkg::FPE_BIT_PROG] = 1'b0;
            end
            if (!(software_write_enable && setup_r[fpe_pkg::FPE_BIT_ESU] && !err)) begin
                ctrl1_nxt[fpe_pkg::FPE_BIT_ERASE] = 1'b0;
            end
        end
    end

    // Setup register: error flag set by hardware only, never by software
    always_comb begin
        setup_nxt = setup_r;
        if (clr_all) begin
            setup_nxt = fpe_pkg::FPE_RST8;
        end else begin
            if (is_wr(addr, fpe_pkg::FPE_OFF_SETUP, wr) && !mode.flash_disabled) begin
                setup_nxt[1:0] = wb[1:0] & fpe_pkg::FPE_SETUP_MASK[1:0];
            end
            if (mode.low_power) begin
                setup_nxt[1:0] = 2'h0;
            end
            if (flash_error && (state_r != fpe_pkg::FPE_IDLE)) begin
                setup_nxt[fpe_pkg::FPE_BIT_ERR] = 1'b1;
            end
        end
    end

    // Block-select registers, held clear outside an enabled session
    always_comb begin
        ebh_nxt = ebh_r;
        ebl_nxt = ebl_r;
        if (is_wr(addr, fpe_pkg::FPE_OFF_EBH, wr) && !mode.flash_disabled) begin
            ebh_nxt = wb & fpe_pkg::FPE_EBH_MASK;
            if (mode.normal_mode) begin
                ebh_nxt[1:0] = fpe_pkg::FPE_EBH_NORMAL_MASK;
            end
        end
        if (is_wr(addr, fpe_pkg::FPE_OFF_EBL, wr) && !mode.flash_disabled) begin
            ebl_nxt = mode.normal_mode ? (wb & fpe_pkg::FPE_EBL_NORMAL_MASK) : wb;
        end
        if (clr_all || mode.low_power || !software_write_enable) begin
            ebh_nxt = fpe_pkg::FPE_RST8;
            ebl_nxt = fpe_pkg::FPE_RST8;
        end
    end

    always_comb begin
        mask_nxt = mask_r;
        if (is_wr(addr, fpe_pkg::FPE_OFF_IRQ_MASK, wr)) begin
            mask_nxt = wb[fpe_pkg::FPE_NIRQ-1:0];
        end
        irq_clr = is_wr(addr, fpe_pkg::FPE_OFF_IRQ_STAT, wr) ? wb[fpe_pkg::FPE_NIRQ-1:0] : '0;
    end

    // Operation state tracks the flash mode driven out
    always_comb begin
        case (state_r)
            fpe_pkg::FPE_IDLE: begin
                if (ctrl1_r[fpe_pkg::FPE_BIT_PROG]) begin
                    state_nxt = fpe_pkg::FPE_PROG;
                end else if (ctrl1_r[fpe_pkg::FPE_BIT_ERASE]) begin
                    state_nxt = fpe_pkg::FPE_ERASE;
                end else begin
                    state_nxt = fpe_pkg::FPE_IDLE;
                end
            end
            fpe_pkg::FPE_PROG: begin
                state_nxt = ctrl1_r[fpe_pkg::FPE_BIT_PROG] ? fpe_pkg::FPE_PROG : fpe_pkg::FPE_IDLE;
            end
            fpe_pkg::FPE_ERASE: begin
                state_nxt = ctrl1_r[fpe_pkg::FPE_BIT_ERASE] ? fpe_pkg::FPE_ERASE : fpe_pkg::FPE_IDLE;
            end
            default: begin
                state_nxt = fpe_pkg::FPE_IDLE;
            end
        endcase
        if (err) begin
            state_nxt = fpe_pkg::FPE_IDLE;
        end
        irq_evt = '0;
        irq_evt[fpe_pkg::FPE_IRQ_ERR] = setup_nxt[fpe_pkg::FPE_BIT_ERR] & ~err;
        irq_evt[fpe_pkg::FPE_IRQ_PROG] = (state_r == fpe_pkg::FPE_PROG)
            && (state_nxt == fpe_pkg::FPE_IDLE);
        irq_evt[fpe_pkg::FPE_IRQ_ERASE] = (state_r == fpe_pkg::FPE_ERASE)
            && (state_nxt == fpe_pkg::FPE_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl1_r <= fpe_pkg::FPE_RST8;
            setup_r <= fpe_pkg::FPE_RST8;
            ebh_r <= fpe_pkg::FPE_RST8;
            ebl_r <= fpe_pkg::FPE_RST8;
            mask_r <= '0;
            state_r <= fpe_pkg::FPE_IDLE;
        end else if (clk_en) begin
            ctrl1_r <= ctrl1_nxt;
            setup_r <= setup_nxt;
            ebh_r <= ebh_nxt;
            ebl_r <= ebl_nxt;
            mask_r <= mask_nxt;
            state_r <= state_nxt;
        end
    end

    fpe_irq #(.N(fpe_pkg::FPE_NIRQ)) u_irq (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .event_in(irq_evt),
        .clear_in(irq_clr),
        .mask_in(mask_r),
        .status(irq_stat),
        .irq(irq)
    );

    // Reads of setup and block-select registers return zero while the flash is disabled
    always_comb begin
        rdata = 32'h0000_0000;
        case (addr)
            fpe_pkg::FPE_OFF_CTRL1: rdata[7:0] = ctrl1_r;
            fpe_pkg::FPE_OFF_SETUP: rdata[7:0] = mode.flash_disabled ? 8'h00 : setup_r;
            fpe_pkg::FPE_OFF_EBH: begin
                rdata[7:0] = mode.flash_disabled ? 8'h00 : ebh_r;
                // Bits set before normal mode was entered must still read as zero
                if (mode.normal_mode) begin
                    rdata[7:0] = 8'h00;
                end
            end
            fpe_pkg::FPE_OFF_EBL: begin
                rdata[7:0] = mode.flash_disabled ? 8'h00 : ebl_r;
                if (mode.normal_mode) begin
                    rdata[7] = 1'b0;
                end
            end
            fpe_pkg::FPE_OFF_IRQ_STAT: rdata[fpe_pkg::FPE_NIRQ-1:0] = irq_stat;
            fpe_pkg::FPE_OFF_IRQ_MASK: rdata[fpe_pkg::FPE_NIRQ-1:0] = mask_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Erase enables only the selected block; relies on software choosing one
    always_comb begin
        flash_ctl.prog_active = (state_r == fpe_pkg::FPE_PROG);
        flash_ctl.erase_active = (state_r == fpe_pkg::FPE_ERASE);
        flash_ctl.erase_allow = (state_r == fpe_pkg::FPE_ERASE)
            ? {ebh_r[1:0], ebl_r} : '0;
    end

    a_prog_needs_setup: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && $rose(ctrl1_r[0])) |-> $past(software_write_enable) && $past(setup_r[0]) && !$past(err))
        else $error("program bit set without enable and setup");
    a_setup_hw_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.hw_standby) |=> (setup_r == 8'h00))
        else $error("setup register not cleared in hardware standby");
    a_lowpower_setup: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.low_power) |=> (setup_r[1:0] == 2'h0))
        else $error("setup bits survive low power");
    a_disabled_rd_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && mode.flash_disabled && (addr == fpe_pkg::FPE_OFF_SETUP
            || addr == fpe_pkg::FPE_OFF_EBL || addr == fpe_pkg::FPE_OFF_EBH)) |-> (prdata == 32'h0))
        else $error("disabled flash register read not zero");
    a_err_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && err && !mode.hw_standby) |=> err)
        else $error("error flag dropped without standby");
    a_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (setup_r[6:2] == 5'h00) && (ebh_r[7:2] == 6'h00))
        else $error("unused bits not zero");
    a_normal_masked: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.normal_mode && wr) |=> (ebh_r[1:0] == 2'h0 || $past(ebh_r[1:0]) == ebh_r[1:0])
            && (ebl_r[7] == 1'b0 || $past(ebl_r[7])))
        else $error("normal mode wrote masked select bit");
    a_sel_cleared: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !software_write_enable) |=> (ebh_r == 8'h00) && (ebl_r == 8'h00))
        else $error("select registers not cleared without enable");
    a_erase_only_sel: assert property (@(posedge clk) disable iff (!reset_n)
        ((flash_ctl.erase_allow & ~{ebh_r[1:0], ebl_r}) == '0))
        else $error("unselected block erasable");
    a_err_blocks: assert property (@(posedge clk) disable iff (!reset_n)
        err |=> !flash_ctl.prog_active && !flash_ctl.erase_active)
        else $error("program or erase active with error flag");
    a_prog_bit_pos: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && wr && addr == fpe_pkg::FPE_OFF_CTRL1 && !mode.flash_disabled && !mode.hw_standby
            && software_write_enable && setup_r[0] && !err) |=> (ctrl1_r[0] == $past(pwdata[0])))
        else $error("program bit not taken from bit 0");
    a_erase_gated: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && $rose(ctrl1_r[1])) |-> $past(software_write_enable) && $past(setup_r[1]) && !$past(err))
        else $error("erase bit set without enable and setup");
    a_disabled_setup: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.flash_disabled && !mode.hw_standby && !mode.low_power)
            |=> $stable(setup_r[1:0]))
        else $error("setup bits changed while flash disabled");
    a_disabled_sel: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.flash_disabled && software_write_enable && !mode.hw_standby && !mode.low_power)
            |=> $stable(ebl_r) && $stable(ebh_r))
        else $error("select registers changed while flash disabled");
    a_lowpower_sel: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.low_power) |=> (ebh_r == 8'h00) && (ebl_r == 8'h00))
        else $error("select registers survive low power");
    a_err_set: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && flash_error && state_r != fpe_pkg::FPE_IDLE && !mode.hw_standby) |=> err)
        else $error("error flag not set by array error");
    a_normal_rd_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && !pwrite && mode.normal_mode && addr == fpe_pkg::FPE_OFF_EBH)
            |-> (prdata == 32'h0))
        else $error("normal mode high select read not zero");
    a_ebh_normal_wr: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && mode.normal_mode && wr && addr == fpe_pkg::FPE_OFF_EBH)
            |=> (ebh_r[1:0] == 2'h0))
        else $error("normal mode write reached high select bits");
    a_setup_wr: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && wr && addr == fpe_pkg::FPE_OFF_SETUP && !mode.flash_disabled
            && !mode.hw_standby && !mode.low_power) |=> (setup_r[1:0] == $past(pwdata[1:0])))
        else $error("setup bits not written at bits 1 and 0");
    a_state_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot(state_r))
        else $error("operation state not one-hot");
endmodule // fpe_flash_pe_ctrl

// ===== fpe_pkg.sv
// Package with register map, field positions, reset values and carrier types
// Summary of operation
// - Program mode needs enable and program setup
// - Setup register clears on reset, hardware standby
// - Setup bits clear in low-power modes
// - Setup register reads zero, ignores writes when disabled
// - Error flag bit 7, read-only, sets protection
// - Erase setup bit 1, program setup bit 0
// - High select bits 1:0, low bits 7:0
// - Normal mode: blocks 9,8,7 read zero, fixed
// - Select registers clear in standby, without enable
// - Only the selected block may be erased
// - Select registers read zero when flash disabled
// - Program bit at bit 0 of first control
package fpe_pkg;
    localparam logic [11:0] FPE_OFF_CTRL1 = 12'h000;
    localparam logic [11:0] FPE_OFF_SETUP = 12'h004;
    localparam logic [11:0] FPE_OFF_EBH = 12'h008;
    localparam logic [11:0] FPE_OFF_EBL = 12'h00c;
    localparam logic [11:0] FPE_OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] FPE_OFF_IRQ_MASK = 12'h014;
    localparam int FPE_BIT_PROG = 0;
    localparam int FPE_BIT_ERASE = 1;
    localparam int FPE_BIT_PV = 2;
    localparam int FPE_BIT_EV = 3;
    localparam int FPE_BIT_SWE = 6;
    localparam int FPE_BIT_PSU = 0;
    localparam int FPE_BIT_ESU = 1;
    localparam int FPE_BIT_ERR = 7;
    localparam logic [7:0] FPE_RST8 = 8'h00;
    localparam logic [7:0] FPE_CTRL1_MASK = 8'h4f;
    localparam logic [7:0] FPE_SETUP_MASK = 8'h03;
    localparam logic [7:0] FPE_EBH_MASK = 8'h03;
    localparam logic [7:0] FPE_EBL_NORMAL_MASK = 8'h7f;
    localparam logic [1:0] FPE_EBH_NORMAL_MASK = 2'h0;
    localparam int FPE_NBLK = 10;
    localparam int FPE_NIRQ = 3;
    localparam int FPE_IRQ_ERR = 0;
    localparam int FPE_IRQ_PROG = 1;
    localparam int FPE_IRQ_ERASE = 2;

    typedef struct packed {
        logic hw_standby;
        logic low_power;
        logic flash_disabled;
        logic normal_mode;
    } fpe_mode_t;

    typedef struct packed {
        logic prog_active;
        logic erase_active;
        logic [FPE_NBLK-1:0] erase_allow;
    } fpe_flash_ctl_t;

    typedef enum logic [2:0] {
        FPE_IDLE = 3'b001,
        FPE_PROG = 3'b010,
        FPE_ERASE = 3'b100
    } fpe_state_t;
endpackage

// ===== fpe_irq.sv
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module fpe_irq #(
    parameter int N = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [N-1:0] event_in,
    input wire logic [N-1:0] clear_in,
    input wire logic [N-1:0] mask_in,
    output logic [N-1:0] status,
    output logic irq
);
    logic [N-1:0] stat_r;
    logic [N-1:0] stat_nxt;

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        stat_nxt = (stat_r & ~clear_in) | event_in;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_r <= '0;
        end else if (clk_en) begin
            stat_r <= stat_nxt;
        end
    end

    assign status = stat_r;
    assign irq = |(stat_r & mask_in);
endmodule // fpe_irq

// ===== fpe_apb.sv
// APB slave front end: decode of strobes, zero-wait answer
`timescale 1ns/1ps
module fpe_apb (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] rdata_in,
    input wire logic map_hit,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic wr_strobe,
    output logic [11:0] reg_addr
);
    // Single-cycle access phase; unmapped offsets answer with an error
    always_comb begin
        pready = psel & penable;
        pslverr = psel & penable & ~map_hit;
        wr_strobe = psel & penable & pwrite & map_hit;
        prdata = (psel & penable & ~pwrite & map_hit) ? rdata_in : 32'h0000_0000;
        reg_addr = {paddr[11:2], 2'b00};
    end
endmodule // fpe_apb

// ===== test_flash_program_erase_control.sv
// Self-checking testbench for the flash program/erase control block
`timescale 1ns/1ps
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); \
    end \
end
module test_flash_program_erase_control;
    localparam logic [11:0] A_C1 = fpe_pkg::FPE_OFF_CTRL1;
    localparam logic [11:0] A_SU = fpe_pkg::FPE_OFF_SETUP;
    localparam logic [11:0] A_EH = fpe_pkg::FPE_OFF_EBH;
    localparam logic [11:0] A_EL = fpe_pkg::FPE_OFF_EBL;
    localparam logic [11:0] A_ST = fpe_pkg::FPE_OFF_IRQ_STAT;
    localparam logic [11:0] A_MK = fpe_pkg::FPE_OFF_IRQ_MASK;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fpe_pkg::fpe_mode_t mode = '0;
    logic flash_error = 1'b0;
    fpe_pkg::fpe_flash_ctl_t flash_ctl;
    logic irq;
    logic [31:0] rd_data;
    logic rd_err;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    fpe_flash_pe_ctrl DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
        .flash_error(flash_error), .flash_ctl(flash_ctl), .irq(irq));

    always #50 clk = ~clk;

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang shows as a cycle count far beyond the whole sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
        xfer(1'b0, a, 8'h00);
        `CHK(rd_data, {24'h0, e})
        `CHK(rd_err, err)
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rdc(A_C1, 8'h00);
        rdc(A_SU, 8'h00);
        rdc(A_EH, 8'h00);
        rdc(A_EL, 8'h00);
        rdc(A_MK, 8'h00);
        rdc(12'h020, 8'h00, 1'b1);
        // Selects stay clear while write enable is off
        wr(A_EL, 8'h08);
        rdc(A_EL, 8'h00);
        wr(A_SU, 8'hff);
        rdc(A_SU, 8'h03);
        wr(A_C1, 8'h40);
        wr(A_EH, 8'hfe);
        rdc(A_EH, 8'h02);
        wr(A_EH, 8'h00);
        wr(A_EL, 8'h80);
        rdc(A_EL, 8'h80);
        mode.normal_mode <= 1'b1;
        wr(A_EL, 8'h00);
        wr(A_EH, 8'h01);
        rdc(A_EH, 8'h00);
        wr(A_EL, 8'h80);
        rdc(A_EL, 8'h00);
        wr(A_EL, 8'h02);
        rdc(A_EL, 8'h02);
        mode.normal_mode <= 1'b0;
        // Low-power entry drops setup bits and block selects
        @(posedge clk);
        mode.low_power <= 1'b1;
        @(posedge clk);
        mode.low_power <= 1'b0;
        rdc(A_SU, 8'h00);
        rdc(A_EL, 8'h00);
        wr(A_C1, 8'h40);
        wr(A_EL, 8'h20);
        wr(A_C1, 8'h00);
        rdc(A_EL, 8'h00);
        wr(A_C1, 8'h40);
        wr(A_EL, 8'h20);
        mode.flash_disabled <= 1'b1;
        rdc(A_EL, 8'h00);
        wr(A_EL, 8'h01);
        wr(A_SU, 8'h01);
        rdc(A_SU, 8'h00);
        mode.flash_disabled <= 1'b0;
        rdc(A_EL, 8'h20);
        rdc(A_SU, 8'h00);
        // Program bit refused without program setup
        wr(A_C1, 8'h41);
        rdc(A_C1, 8'h40);
        wr(A_SU, 8'h01);
        wr(A_C1, 8'h41);
        rdc(A_C1, 8'h41);
        settle();
        `CHK(flash_ctl.prog_active, 1'b1)
        wr(A_C1, 8'h40);
        settle();
        `CHK(flash_ctl.prog_active, 1'b0)
        wr(A_EL, 8'h04);
        wr(A_SU, 8'h02);
        wr(A_C1, 8'h42);
        settle();
        `CHK(flash_ctl.erase_active, 1'b1)
        `CHK(flash_ctl.erase_allow, 10'h004)
        wr(A_C1, 8'h40);
        wr(A_SU, 8'h01);
        wr(A_C1, 8'h41);
        settle();
        // Array error while programming latches the flag and an interrupt
        @(posedge clk);
        flash_error <= 1'b1;
        @(posedge clk);
        flash_error <= 1'b0;
        rdc(A_SU, 8'h81);
        `CHK(irq, 1'b0)
        wr(A_MK, 8'h01);
        settle();
        `CHK(irq, 1'b1)
        wr(A_ST, 8'h01);
        settle();
        `CHK(irq, 1'b0)
        // A frozen clock enable must swallow the write
        @(posedge clk);
        clk_en <= 1'b0;
        wr(A_MK, 8'h06);
        clk_en <= 1'b1;
        rdc(A_MK, 8'h01);
        wr(A_C1, 8'h40);
        wr(A_C1, 8'h41);
        rdc(A_C1, 8'h40);
        @(posedge clk);
        mode.hw_standby <= 1'b1;
        @(posedge clk);
        mode.hw_standby <= 1'b0;
        rdc(A_SU, 8'h00);
        rdc(A_EL, 8'h00);
        rdc(A_EH, 8'h00);
        conclude();
    end
endmodule // test_flash_program_erase_control
